// File: rtl/fwsr_host.sv
// Purpose: host that polls flash program/erase status over its pins
// Assumes: APB master; flash pins timed by core_clk
// Notes: one operation at a time, orders refused while busy
//
// Notes on behaviour
// - host combines sector toggle and busy toggle to learn sector and mode.
// - host may time status reads by output strobe or chip select.
// - host starts each check with two back-to-back full byte reads.
// - unchanged toggle means done; next read returns array data.
// - toggling with timeout flag high: recheck, still toggling means fail, send reset.
// - a paused poll restarts from its first double read.
// - after any timeout failure the host writes the reset command.
// - host may skip window checks only if commands come within 50 us.
// - host checks window flag before and after each added sector erase.
// - status reads use an address inside the sector being worked on.
module fwsr_host #(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [AW-1:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_i
);
	fwsr_pkg::fwsr_state_t st_r;
	fwsr_pkg::fwsr_op_t op_r;
	logic use_ce_r, ign_win_r, stop_r, go_p;
	logic [AW-1:0] addr_r;
	logic [7:0] wdata_r;
	logic issued_r, bc_start_r, bc_wr_r, bc_done;
	logic [AW-1:0] bc_addr_r;
	logic [7:0] bc_wdata_r, bc_rdata;
	logic busy_tog, sect_tog, tmo;
	logic ok_r, fail_r, erasing_r, susp_r, win_r, nacc_r, refused_r, rstsent_r;
	logic [7:0] last_r;
	logic [15:0] gap_r;
	logic seen_gw_r, fast;
	logic [2:0] rd_cnt_r;
	logic is_bus, go_ok, apb_acc, apb_wr, mode_erasing;

	assign is_bus = !(st_r == fwsr_pkg::S_IDLE || st_r == fwsr_pkg::S_EV1 || st_r == fwsr_pkg::S_EV2);
	assign go_ok = go_p && st_r == fwsr_pkg::S_IDLE;
	assign apb_acc = psel && penable && pready;
	assign apb_wr = apb_acc && pwrite;
	assign fast = seen_gw_r && gap_r < 16'(fwsr_pkg::WIN_GAP_CYC);
	assign mode_erasing = busy_tog && sect_tog;

	// ------------------------------------------------------------
	// apb slave: one wait-free access phase
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pready) begin
				case (paddr)
					fwsr_pkg::OFF_CTRL: prdata <= 32'({ign_win_r, use_ce_r, op_r});
					fwsr_pkg::OFF_ADDR: prdata <= 32'(addr_r);
					fwsr_pkg::OFF_WDATA: prdata <= 32'(wdata_r);
					fwsr_pkg::OFF_STATUS: begin
						prdata[fwsr_pkg::ST_BUSY] <= st_r != fwsr_pkg::S_IDLE;
						prdata[fwsr_pkg::ST_OK] <= ok_r;
						prdata[fwsr_pkg::ST_FAIL] <= fail_r;
						prdata[fwsr_pkg::ST_ERASING] <= erasing_r;
						prdata[fwsr_pkg::ST_SUSP] <= susp_r;
						prdata[fwsr_pkg::ST_WIN] <= win_r;
						prdata[fwsr_pkg::ST_NACC] <= nacc_r;
						prdata[fwsr_pkg::ST_REFUSED] <= refused_r;
						prdata[fwsr_pkg::ST_DATA_LSB +: 8] <= last_r;
						prdata[fwsr_pkg::ST_RSTSENT] <= rstsent_r;
					end
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			op_r <= fwsr_pkg::OP_NONE;
			use_ce_r <= 1'b0;
			ign_win_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= 8'h00;
			go_p <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			go_p <= 1'b0;
			if (go_ok) begin
				stop_r <= 1'b0;
			end
			if (apb_wr && paddr == fwsr_pkg::OFF_CTRL) begin
				op_r <= fwsr_pkg::fwsr_op_t'(pwdata[fwsr_pkg::CTRL_OP_LSB +: 3]);
				use_ce_r <= pwdata[fwsr_pkg::CTRL_USE_CE];
				ign_win_r <= pwdata[fwsr_pkg::CTRL_IGN_WIN];
				go_p <= pwdata[fwsr_pkg::CTRL_GO];
				if (pwdata[fwsr_pkg::CTRL_STOP]) begin
					stop_r <= 1'b1;
				end
			end
			if (apb_wr && paddr == fwsr_pkg::OFF_ADDR) begin
				addr_r <= pwdata[AW-1:0];
			end
			if (apb_wr && paddr == fwsr_pkg::OFF_WDATA) begin
				wdata_r <= pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= fwsr_pkg::S_IDLE;
		end else begin
			case (st_r)
				fwsr_pkg::S_IDLE: begin
					if (go_ok) begin
						case (op_r)
							fwsr_pkg::OP_READ: st_r <= fwsr_pkg::S_READ;
							fwsr_pkg::OP_WRITE: st_r <= fwsr_pkg::S_WRITE;
							fwsr_pkg::OP_POLL: st_r <= fwsr_pkg::S_RD1;
							fwsr_pkg::OP_WIN: st_r <= fwsr_pkg::S_WIN;
							// skip both checks only when added commands come fast enough
							fwsr_pkg::OP_GWRITE: st_r <= (ign_win_r && fast) ? fwsr_pkg::S_GWR : fwsr_pkg::S_PRE;
							default: st_r <= fwsr_pkg::S_IDLE;
						endcase
					end
				end
				fwsr_pkg::S_EV1: begin
					if (!busy_tog) begin
						st_r <= fwsr_pkg::S_ARRAY;
					end else if (tmo) begin
						st_r <= fwsr_pkg::S_RD3;
					end else begin
						// a stopped poll leaves no state; the next one starts over
						st_r <= stop_r ? fwsr_pkg::S_IDLE : fwsr_pkg::S_RD1;
					end
				end
				fwsr_pkg::S_EV2: st_r <= busy_tog ? fwsr_pkg::S_RSTCMD : fwsr_pkg::S_ARRAY;
				default: begin
					if (bc_done) begin
						case (st_r)
							fwsr_pkg::S_RD1: st_r <= fwsr_pkg::S_RD2;
							fwsr_pkg::S_RD2: st_r <= fwsr_pkg::S_EV1;
							fwsr_pkg::S_RD3: st_r <= fwsr_pkg::S_RD4;
							fwsr_pkg::S_RD4: st_r <= fwsr_pkg::S_EV2;
							fwsr_pkg::S_PRE: st_r <= bc_rdata[fwsr_pkg::BIT_WIN] ? fwsr_pkg::S_IDLE : fwsr_pkg::S_GWR;
							fwsr_pkg::S_GWR: st_r <= ign_win_r && fast ? fwsr_pkg::S_IDLE : fwsr_pkg::S_POST;
							default: st_r <= fwsr_pkg::S_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	// one bus cycle per bus state; reset command goes to address zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			issued_r <= 1'b0;
			bc_start_r <= 1'b0;
			bc_wr_r <= 1'b0;
			bc_addr_r <= '0;
			bc_wdata_r <= 8'h00;
		end else begin
			bc_start_r <= 1'b0;
			if (bc_done) begin
				issued_r <= 1'b0;
			end else if (is_bus && !issued_r) begin
				issued_r <= 1'b1;
				bc_start_r <= 1'b1;
				bc_wr_r <= st_r == fwsr_pkg::S_WRITE || st_r == fwsr_pkg::S_GWR || st_r == fwsr_pkg::S_RSTCMD;
				bc_addr_r <= (st_r == fwsr_pkg::S_RSTCMD) ? '0 : addr_r;
				bc_wdata_r <= (st_r == fwsr_pkg::S_RSTCMD) ? fwsr_pkg::RESET_CMD : wdata_r;
			end
		end
	end

	// ------------------------------------------------------------
	// status
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ok_r <= 1'b0;
			fail_r <= 1'b0;
			erasing_r <= 1'b0;
			susp_r <= 1'b0;
			win_r <= 1'b0;
			nacc_r <= 1'b0;
			refused_r <= 1'b0;
			rstsent_r <= 1'b0;
			last_r <= 8'h00;
		end else begin
			if (go_ok) begin
				ok_r <= 1'b0;
				fail_r <= 1'b0;
				nacc_r <= 1'b0;
				rstsent_r <= 1'b0;
				refused_r <= 1'b0;
			end
			if (go_p && st_r != fwsr_pkg::S_IDLE) begin
				refused_r <= 1'b1;
			end
			if (bc_done && !bc_wr_r) begin
				last_r <= bc_rdata;
			end
			if (st_r == fwsr_pkg::S_EV1) begin
				erasing_r <= mode_erasing;
				susp_r <= sect_tog && !busy_tog;
			end
			if (st_r == fwsr_pkg::S_EV2 && busy_tog) begin
				fail_r <= 1'b1;
			end
			if (bc_done && st_r == fwsr_pkg::S_ARRAY) begin
				ok_r <= 1'b1;
			end
			if (bc_done && st_r == fwsr_pkg::S_RSTCMD) begin
				rstsent_r <= 1'b1;
			end
			if (bc_done && (st_r == fwsr_pkg::S_WIN || st_r == fwsr_pkg::S_PRE || st_r == fwsr_pkg::S_POST)) begin
				win_r <= bc_rdata[fwsr_pkg::BIT_WIN];
			end
			// high on either check: the added erase may not have been taken
			if (bc_done && (st_r == fwsr_pkg::S_PRE || st_r == fwsr_pkg::S_POST) && bc_rdata[fwsr_pkg::BIT_WIN]) begin
				nacc_r <= 1'b1;
			end
		end
	end

	// time since the last added sector erase write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gap_r <= 16'h0000;
			seen_gw_r <= 1'b0;
		end else if (bc_done && st_r == fwsr_pkg::S_GWR) begin
			gap_r <= 16'h0000;
			seen_gw_r <= 1'b1;
		end else if (gap_r < 16'(fwsr_pkg::WIN_GAP_CYC)) begin
			gap_r <= gap_r + 16'h0001;
		end
	end

	// completed status reads since the latest first read (S_RD1) of the current poll
	always_ff @(posedge core_clk) begin
		if (rst || go_ok || st_r == fwsr_pkg::S_RD1 && bc_start_r) begin
			rd_cnt_r <= (!rst && !go_ok) ? 3'h0 : 3'h0;
		end else if (bc_done && !bc_wr_r && rd_cnt_r != 3'h7) begin
			rd_cnt_r <= rd_cnt_r + 3'h1;
		end
	end

	fwsr_bus_cycle #(.AW(AW)) u_cycle (
		.core_clk(core_clk),
		.rst(rst),
		.start(bc_start_r),
		.wr(bc_wr_r),
		.use_ce(use_ce_r),
		.addr(bc_addr_r),
		.wdata(bc_wdata_r),
		.done(bc_done),
		.rdata(bc_rdata),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i)
	);

	fwsr_toggle_cmp u_cmp (
		.core_clk(core_clk),
		.rst(rst),
		.load(bc_done && (st_r == fwsr_pkg::S_RD1 || st_r == fwsr_pkg::S_RD3)),
		.cmp(bc_done && (st_r == fwsr_pkg::S_RD2 || st_r == fwsr_pkg::S_RD4)),
		.byte_i(bc_rdata),
		.busy_tog(busy_tog),
		.sect_tog(sect_tog),
		.tmo(tmo)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_fail_decided;
		st_r == fwsr_pkg::S_EV2 && busy_tog;
	endsequence
	sequence s_reset_issued;
		##[1:40] (bc_start_r && bc_wr_r && bc_wdata_r == fwsr_pkg::RESET_CMD);
	endsequence
	property p_reset_after_fail;
		@(posedge core_clk) disable iff (rst) s_fail_decided |-> s_reset_issued;
	endproperty
	a_reset_after_fail: assert property (p_reset_after_fail) else $error("no reset command after failure");
	property p_two_reads;
		@(posedge core_clk) disable iff (rst) st_r == fwsr_pkg::S_EV1 |-> rd_cnt_r == 3'h2;
	endproperty
	a_two_reads: assert property (p_two_reads) else $error("toggle judged without two reads");
	property p_recheck;
		@(posedge core_clk) disable iff (rst) $rose(fail_r) |-> rd_cnt_r == 3'h4 && $past(tmo);
	endproperty
	a_recheck: assert property (p_recheck) else $error("failure without timeout recheck");
	property p_restart;
		@(posedge core_clk) disable iff (rst)
		(go_ok && op_r == fwsr_pkg::OP_POLL) |=> st_r == fwsr_pkg::S_RD1 ##1 bc_start_r && !bc_wr_r;
	endproperty
	a_restart: assert property (p_restart) else $error("poll did not start with first read");
	property p_valid_addr;
		@(posedge core_clk) disable iff (rst)
		(bc_start_r && !bc_wr_r && st_r != fwsr_pkg::S_IDLE) |-> bc_addr_r == addr_r;
	endproperty
	a_valid_addr: assert property (p_valid_addr) else $error("status read off the chosen sector");
	property p_complete;
		@(posedge core_clk) disable iff (rst)
		(st_r == fwsr_pkg::S_EV1 && !busy_tog) |=> st_r == fwsr_pkg::S_ARRAY ##1 bc_start_r && !bc_wr_r;
	endproperty
	a_complete: assert property (p_complete) else $error("no array read after completion");
	property p_mode;
		@(posedge core_clk) disable iff (rst)
		st_r == fwsr_pkg::S_EV1 |=> erasing_r == $past(mode_erasing) && susp_r == (sect_tog && !busy_tog);
	endproperty
	a_mode: assert property (p_mode) else $error("mode not from both toggle bits");
	property p_pre_check;
		@(posedge core_clk) disable iff (rst)
		(st_r == fwsr_pkg::S_PRE && bc_done && bc_rdata[fwsr_pkg::BIT_WIN]) |=> st_r == fwsr_pkg::S_IDLE && nacc_r;
	endproperty
	a_pre_check: assert property (p_pre_check) else $error("erase added with window closed");
	property p_fast_skip;
		@(posedge core_clk) disable iff (rst)
		(go_ok && op_r == fwsr_pkg::OP_GWRITE && !(ign_win_r && fast)) |=> st_r == fwsr_pkg::S_PRE;
	endproperty
	a_fast_skip: assert property (p_fast_skip) else $error("window check skipped");
	property p_apb_once;
		@(posedge core_clk) disable iff (rst) apb_acc |=> !pready;
	endproperty
	a_apb_once: assert property (p_apb_once) else $error("pready held past access");
endmodule : fwsr_host

// File: rtl/fwsr_pkg.sv
// Purpose: shared constants and types of the flash status polling host
// Assumes: core_clk at 10 MHz
// Notes: register map, field positions and strobe timing live here
package fwsr_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int RD_PULSE_NS = 200;
	localparam int RD_PULSE_CYC = (RD_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_PULSE_NS = 100;
	localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WIN_GAP_US = 50;
	// longest gap, exact in whole cycles
	localparam int WIN_GAP_CYC = WIN_GAP_US * CLK_MHZ;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_USE_CE = 3;
	localparam int CTRL_IGN_WIN = 4;
	localparam int CTRL_GO = 8;
	localparam int CTRL_STOP = 9;
	localparam int ST_BUSY = 0;
	localparam int ST_OK = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_ERASING = 3;
	localparam int ST_SUSP = 4;
	localparam int ST_WIN = 5;
	localparam int ST_NACC = 6;
	localparam int ST_REFUSED = 7;
	localparam int ST_DATA_LSB = 8;
	localparam int ST_RSTSENT = 16;
	localparam logic [2:0] CTRL_OP_RST = 3'h0;

	// ------------------------------------------------------------
	// flash status byte
	// ------------------------------------------------------------
	localparam int BIT_SECT_TOG = 2;
	localparam int BIT_WIN = 3;
	localparam int BIT_TMO = 5;
	localparam int BIT_BUSY_TOG = 6;
	localparam logic [7:0] RESET_CMD = 8'hf0;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_READ = 3'b001,
		OP_WRITE = 3'b010,
		OP_POLL = 3'b011,
		OP_WIN = 3'b100,
		OP_GWRITE = 3'b101
	} fwsr_op_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_READ = 4'b0001,
		S_WRITE = 4'b0010,
		S_RD1 = 4'b0011,
		S_RD2 = 4'b0100,
		S_EV1 = 4'b0101,
		S_RD3 = 4'b0110,
		S_RD4 = 4'b0111,
		S_EV2 = 4'b1000,
		S_ARRAY = 4'b1001,
		S_RSTCMD = 4'b1010,
		S_WIN = 4'b1011,
		S_PRE = 4'b1100,
		S_GWR = 4'b1101,
		S_POST = 4'b1110
	} fwsr_state_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_PULSE = 2'b10,
		PH_HOLD = 2'b11
	} fwsr_phase_t;
endpackage : fwsr_pkg

// File: rtl/fwsr_bus_cycle.sv
// Purpose: one asynchronous flash read or write cycle on the pins
// Assumes: start only while idle
// Notes: held control low for the whole cycle, strobe low in the pulse
module fwsr_bus_cycle #(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic wr,
	input wire logic use_ce,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic [7:0] rdata,
	// flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [AW-1:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_i
);
	fwsr_pkg::fwsr_phase_t ph_r;
	logic [7:0] cnt_r;
	logic wr_r;
	logic use_ce_r;
	logic held_nxt;
	logic strobe_nxt;
	logic wr_s;
	logic ce_s;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ph_r <= fwsr_pkg::PH_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			use_ce_r <= 1'b0;
		end else begin
			case (ph_r)
				fwsr_pkg::PH_IDLE: begin
					if (start) begin
						ph_r <= fwsr_pkg::PH_SETUP;
						wr_r <= wr;
						use_ce_r <= use_ce;
					end
				end
				fwsr_pkg::PH_SETUP: begin
					ph_r <= fwsr_pkg::PH_PULSE;
					cnt_r <= wr_r ? 8'(fwsr_pkg::WR_PULSE_CYC - 1) : 8'(fwsr_pkg::RD_PULSE_CYC - 1);
				end
				fwsr_pkg::PH_PULSE: begin
					if (cnt_r == 8'h00) begin
						ph_r <= fwsr_pkg::PH_HOLD;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: ph_r <= fwsr_pkg::PH_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin levels for the coming cycle
	// ------------------------------------------------------------
	always_comb begin
		wr_s = (ph_r == fwsr_pkg::PH_IDLE) ? wr : wr_r;
		ce_s = (ph_r == fwsr_pkg::PH_IDLE) ? use_ce : use_ce_r;
		held_nxt = 1'b1;
		strobe_nxt = 1'b1;
		case (ph_r)
			fwsr_pkg::PH_IDLE: held_nxt = !start;
			fwsr_pkg::PH_SETUP: begin
				held_nxt = 1'b0;
				strobe_nxt = 1'b0;
			end
			fwsr_pkg::PH_PULSE: begin
				held_nxt = 1'b0;
				strobe_nxt = (cnt_r == 8'h00);
			end
			default: held_nxt = 1'b1;
		endcase
	end

	// either strobe may time the read; the other control frames it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
		end else begin
			flash_ce_n <= ce_s ? strobe_nxt : held_nxt;
			flash_oe_n <= wr_s ? 1'b1 : (ce_s ? held_nxt : strobe_nxt);
			flash_we_n <= !wr_s ? 1'b1 : (ce_s ? held_nxt : strobe_nxt);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flash_addr <= '0;
			flash_dq_o <= 8'h00;
			flash_dq_oe <= 1'b0;
		end else if (ph_r == fwsr_pkg::PH_IDLE && start) begin
			flash_addr <= addr;
			flash_dq_o <= wdata;
			flash_dq_oe <= wr;
		end else if (ph_r == fwsr_pkg::PH_HOLD) begin
			flash_dq_oe <= 1'b0;
		end
	end

	// sample before the strobe rises, since status changes when it ends
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= 8'h00;
			done <= 1'b0;
		end else begin
			if (ph_r == fwsr_pkg::PH_PULSE && cnt_r == 8'h00 && !wr_r) begin
				rdata <= flash_dq_i;
			end
			done <= (ph_r == fwsr_pkg::PH_HOLD);
		end
	end

	property p_ce_timed_read;
		@(posedge core_clk) disable iff (rst)
		($fell(flash_ce_n) && use_ce_r && !wr_r) |-> !flash_oe_n && $past(flash_oe_n) == 1'b0;
	endproperty
	a_ce_timed_read: assert property (p_ce_timed_read) else $error("ce read strobe without oe held low");
endmodule : fwsr_bus_cycle

// File: rtl/fwsr_toggle_cmp.sv
// Purpose: compares toggle bits of two successive status reads
// Assumes: load and cmp are one-cycle pulses with byte_i valid
// Notes: reference follows each compared byte
module fwsr_toggle_cmp (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// samples
	input wire logic load,
	input wire logic cmp,
	input wire logic [7:0] byte_i,
	// verdict
	output logic busy_tog,
	output logic sect_tog,
	output logic tmo
);
	logic [7:0] ref_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_r <= 8'h00;
			busy_tog <= 1'b0;
			sect_tog <= 1'b0;
			tmo <= 1'b0;
		end else if (load) begin
			ref_r <= byte_i;
		end else if (cmp) begin
			ref_r <= byte_i;
			busy_tog <= ref_r[fwsr_pkg::BIT_BUSY_TOG] ^ byte_i[fwsr_pkg::BIT_BUSY_TOG];
			sect_tog <= ref_r[fwsr_pkg::BIT_SECT_TOG] ^ byte_i[fwsr_pkg::BIT_SECT_TOG];
			tmo <= byte_i[fwsr_pkg::BIT_TMO];
		end
	end
endmodule : fwsr_toggle_cmp

// File: sim/fwsr_flash_model.sv
// Purpose: behavioural flash answering host status reads
// Assumes: the bench sets busy, susp, tmo and win levels
// Notes: a released bus shows the inverse of the last byte
module fwsr_flash_model (
	// flash pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [23:0] addr,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe,
	output logic [7:0] dq_i,
	output logic ready_busy_n,
	// bench side
	input wire logic busy,
	input wire logic susp,
	input wire logic tmo,
	input wire logic win,
	output int wr_cnt,
	output logic [7:0] wr_data,
	output logic [23:0] wr_addr
);
	logic btog = 1'b0;
	logic stog = 1'b0;
	logic [7:0] last = 8'h00;
	wire rd_on = !ce_n && !oe_n && we_n;
	wire wr_on = !ce_n && !we_n;
	wire stat_on = busy || susp || win;
	// timeout flag shown as the bench sets it
	wire [7:0] stat = {1'b0, btog, tmo, 1'b0, win, stog, 2'b00};
	wire [7:0] rbyte = stat_on ? stat : 8'h52;
	// window level stands for sector erase only; no chip erase here
	assign ready_busy_n = !busy;
	assign dq_i = rd_on ? rbyte : ~last;
	initial wr_cnt = 0;
	always @(negedge rd_on) begin
		last = rbyte;
		// flips only when a read ends, whichever strobe ends it
		btog = btog ^ busy;
		stog = stog ^ (busy || susp);
	end
	// commands dropped once the window has closed
	always @(negedge wr_on) begin
		// ce still low: a real write end, not the power-up step; data must be driven
		if (!win && ce_n === 1'b0 && dq_oe) begin
			wr_cnt = wr_cnt + 1;
			wr_data = dq_o;
			wr_addr = addr;
		end
	end
endmodule : fwsr_flash_model

// File: sim/testbench.sv
// Purpose: self-checking bench of the flash status polling host
// Assumes: zero wait APB slave and the flash model on its pins
// Notes: every scenario task judges its own results
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] GO = 32'h0000_0100;
	localparam logic [31:0] POLL = 32'(fwsr_pkg::OP_POLL);
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic [23:0] faddr;
	logic [7:0] dq_o;
	logic [7:0] dq_i;
	logic dq_oe;
	logic rb_n;
	logic busy = 1'b0;
	logic susp = 1'b0;
	logic tmo = 1'b0;
	logic win = 1'b0;
	int wr_cnt;
	logic [7:0] wr_data;
	logic [23:0] wr_addr;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int tests_run = 0;
	int n0;
	always #50 core_clk = !core_clk;
	fwsr_host fwsr_host_inst (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
	fwsr_flash_model fwsr_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
		.dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_n(rb_n), .busy(busy), .susp(susp), .tmo(tmo),
		.win(win), .wr_cnt(wr_cnt),
		.wr_data(wr_data), .wr_addr(wr_addr));
	task automatic tally_and_finish();
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one idle edge first, so a release and a new setup never share a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			$display("Error at %0t: no pready", $time);
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[fwsr_pkg::ST_BUSY] !== 1'b0 && n < 200);
		if (n >= 200) begin
			mismatches++;
			$display("Error at %0t: operation never ended", $time);
			tally_and_finish();
		end
	endtask : wait_idle
	task automatic go(input logic [31:0] ctrl);
		apb(1'b1, fwsr_pkg::OFF_CTRL, ctrl | GO);
		wait_idle();
	endtask : go
	task automatic s_regs();
		apb(1'b0, fwsr_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b1, fwsr_pkg::OFF_ADDR, 32'h0012_3456);
		apb(1'b0, fwsr_pkg::OFF_ADDR, 32'h0);
		chk(rd, 32'h0012_3456);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h0000_0001);
	endtask : s_regs
	task automatic s_done();
		for (int ce = 0; ce < 2; ce++) begin
			go(POLL | (32'(ce) << fwsr_pkg::CTRL_USE_CE));
			chk(rd & 32'h0001_ff1f, 32'h0000_5202);
		end
		susp <= 1'b1;
		go(POLL);
		chk(rd & 32'h0001_001f, 32'h0000_0012);
		susp <= 1'b0;
	endtask : s_done
	task automatic s_fail();
		busy <= 1'b1;
		tmo <= 1'b1;
		go(POLL);
		chk(rd & 32'h0001_001f, 32'h0001_000c);
		chk({wr_addr, wr_data}, 32'h0000_00f0);
		chk({31'h0, rb_n}, 32'h0000_0000);
		tmo <= 1'b0;
	endtask : s_fail
	// second go lands while busy; stop ends the poll with no verdict
	task automatic s_stop();
		apb(1'b1, fwsr_pkg::OFF_CTRL, POLL | GO);
		apb(1'b1, fwsr_pkg::OFF_CTRL, POLL | GO);
		apb(1'b1, fwsr_pkg::OFF_CTRL, 32'h0000_0200);
		wait_idle();
		chk(rd & 32'h0000_0087, 32'h0000_0080);
		busy <= 1'b0;
	endtask : s_stop
	task automatic s_guard();
		apb(1'b1, fwsr_pkg::OFF_ADDR, 32'h0001_0000);
		apb(1'b1, fwsr_pkg::OFF_WDATA, 32'h0000_003c);
		win <= 1'b1;
		go(32'(fwsr_pkg::OP_WIN));
		chk(rd & 32'h0000_0020, 32'h0000_0020);
		n0 = wr_cnt;
		go(32'(fwsr_pkg::OP_GWRITE));
		chk(rd & 32'h0000_0040, 32'h0000_0040);
		chk(32'(wr_cnt - n0), 32'h0000_0000);
		win <= 1'b0;
		go(32'(fwsr_pkg::OP_GWRITE));
		chk(rd & 32'h0000_0040, 32'h0000_0000);
		chk(32'(wr_cnt - n0), 32'h0000_0001);
		chk({wr_addr, wr_data}, 32'h0100_003c);
		// soon after the last added erase: write only, no window reads
		win <= 1'b1;
		go(32'(fwsr_pkg::OP_GWRITE) | (32'h1 << fwsr_pkg::CTRL_IGN_WIN));
		chk(rd & 32'h0000_0060, 32'h0000_0000);
		chk(32'(wr_cnt - n0), 32'h0000_0001);
		// gap too long: checks come back even with ignore set
		repeat (500) @(posedge core_clk);
		go(32'(fwsr_pkg::OP_GWRITE) | (32'h1 << fwsr_pkg::CTRL_IGN_WIN));
		chk(rd & 32'h0000_0040, 32'h0000_0040);
		win <= 1'b0;
	endtask : s_guard
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		s_regs();
		s_done();
		s_fail();
		s_stop();
		s_guard();
		tally_and_finish();
	end
endmodule : testbench
